// File: pkg/ccr_pkg.sv
// package for the charger control register bank
// assumes an axi4-lite master with 32-bit data and a 20 MHz clock
package ccr_pkg;
  // ----------------------------------------------------------------
  // register map (printed offsets are indices, byte address = 4*index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_PRECHG_DONE = 8'h1e;
  localparam logic [7:0] IDX_CHG_TIMER   = 8'h1f;
  localparam logic [7:0] IDX_WEAK_CELL   = 8'h20;
  localparam logic [7:0] IDX_INPUT_LIMIT = 8'h21;
  localparam logic [7:0] IDX_PROTECT     = 8'h30;
  localparam logic [7:0] IDX_CHG_STATUS  = 8'h31;
  localparam int         ADDR_W          = 10;

  // ----------------------------------------------------------------
  // reset values and writable-bit masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PRECHG_DONE = 8'h00;
  localparam logic [7:0] RST_CHG_TIMER   = 8'h00;
  localparam logic [7:0] RST_WEAK_CELL   = 8'h00;
  localparam logic [7:0] RST_INPUT_LIMIT = 8'h00;
  localparam logic [7:0] MSK_PRECHG_DONE = 8'h7f;
  localparam logic [7:0] MSK_CHG_TIMER   = 8'h7f;
  localparam logic [7:0] MSK_WEAK_CELL   = 8'h04;
  localparam logic [7:0] MSK_INPUT_LIMIT = 8'hdf;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_AUTO_RESTART = 6;
  localparam int BIT_WEAK_EN      = 2;
  localparam int BIT_OVERRIDE     = 7;
  localparam int BIT_SUSP_MASK    = 6;
  localparam int LSB_MAINT_TMR    = 4;
  localparam int LSB_WEAK_STATE   = 5;

  // ----------------------------------------------------------------
  // timing: one minute at 20 MHz, maintain timer codes in minutes
  // ----------------------------------------------------------------
  localparam longint CLK_HZ        = 20000000;
  localparam longint MINUTE_CYCLES = CLK_HZ * 60;
  localparam logic [7:0] MT_MIN_00 = 8'h00;
  localparam logic [7:0] MT_MIN_01 = 8'h0f;
  localparam logic [7:0] MT_MIN_10 = 8'h1e;
  localparam logic [7:0] MT_MIN_11 = 8'h3c;
  localparam logic [4:0] LIMIT_RSVD = 5'h1e;

  typedef enum logic [1:0] {CHG_IDLE, CHG_MAINTAIN, CHG_DONE} ccr_chg_t;
  typedef logic [1:0] ccr_resp_t;
  localparam ccr_resp_t RESP_OKAY   = 2'h0;
  localparam ccr_resp_t RESP_SLVERR = 2'h2;
endpackage

// File: logic/ccr_min_timer.sv
// minute-based down counter for the maintain-charge period
// assumes a single clock; minute length is a parameter so benches can shorten it
module ccr_min_timer import ccr_pkg::*; #(
  parameter longint MINUTE = MINUTE_CYCLES
) (
  input  wire logic       clk,      // system clock
  input  wire logic       rstSync_n,// synchronised reset, active low
  input  wire logic       start,    // load the minute count
  input  wire logic [7:0] minutes,  // period in minutes
  output logic            expired   // pulse when period ends
);
  logic [31:0] tickCnt_r, tickCnt_nxt;
  logic [7:0]  minCnt_r, minCnt_nxt;
  logic        run_r, run_nxt, exp_nxt;

  // next state: count clock ticks into minutes, then minutes down
  always_comb begin
    tickCnt_nxt = tickCnt_r;
    minCnt_nxt  = minCnt_r;
    run_nxt     = run_r;
    exp_nxt     = 1'b0;
    if (start) begin
      tickCnt_nxt = 32'(MINUTE - 1);
      minCnt_nxt  = minutes;
      run_nxt     = (minutes != 8'h00);
      exp_nxt     = (minutes == 8'h00); // zero minutes ends at once
    end else if (run_r) begin
      if (tickCnt_r != 32'h0) begin
        tickCnt_nxt = tickCnt_r - 32'h1;
      end else if (minCnt_r == 8'h01) begin
        run_nxt = 1'b0;
        exp_nxt = 1'b1;
      end else begin
        minCnt_nxt  = minCnt_r - 8'h01;
        tickCnt_nxt = 32'(MINUTE - 1);
      end
    end
  end

  // register stage
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      tickCnt_r <= 32'h0;
      minCnt_r  <= 8'h00;
      run_r     <= 1'b0;
      expired   <= 1'b0;
    end else begin
      tickCnt_r <= tickCnt_nxt;
      minCnt_r  <= minCnt_nxt;
      run_r     <= run_nxt;
      expired   <= exp_nxt;
    end
  end
endmodule // ccr_min_timer

// File: logic/ccr_charger_regs.sv
// charger control register bank behind an axi4-lite slave
// assumes the analogue charger supplies cell and detector levels synchronous to clk
// What this block does
// R1: config registers ignore writes while the write-protect flag reads one
// R2: auto-restart bit chooses staying done or restarting below recharge threshold
// R3: maintain timer code maps to 0, 15, 30 or 60 minutes
// R4: override bit selects forced five-bit input limit; codes 11110, 11111 reserved
// R5: suspend mask bit set makes the suspend pin be ignored
// R6: auto-stop control gates the move from maintain charge to done
// R7: weak-cell state is read-only; its enable obeys write protection
module ccr_charger_regs import ccr_pkg::*; #(
  parameter longint MINUTE = MINUTE_CYCLES
) (
  input  wire logic        clk,             // 20 MHz clock
  input  wire logic        rst_n,           // async reset, active low
  input  wire logic [9:0]  s_axi_awaddr,    // write address
  input  wire logic        s_axi_awvalid,   // write address valid
  output logic             s_axi_awready,   // write address ready
  input  wire logic [31:0] s_axi_wdata,     // write data
  input  wire logic [3:0]  s_axi_wstrb,     // byte strobes
  input  wire logic        s_axi_wvalid,    // write data valid
  output logic             s_axi_wready,    // write data ready
  output logic [1:0]       s_axi_bresp,     // write response
  output logic             s_axi_bvalid,    // write response valid
  input  wire logic        s_axi_bready,    // write response ready
  input  wire logic [9:0]  s_axi_araddr,    // read address
  input  wire logic        s_axi_arvalid,   // read address valid
  output logic             s_axi_arready,   // read address ready
  output logic [31:0]      s_axi_rdata,     // read data
  output logic [1:0]       s_axi_rresp,     // read response
  output logic             s_axi_rvalid,    // read data valid
  input  wire logic        s_axi_rready,    // read data ready
  input  wire logic        write_protect_flag, // 1 = protected
  input  wire logic        auto_stop_ctl,   // auto-stop enable
  input  wire logic        charge_enter,    // pulse: enter maintain charge
  input  wire logic        belowRecharge,   // cell under recharge threshold
  input  wire logic [2:0]  weak_cell_state, // weak-cell detector result
  input  wire logic        suspend_pin,     // external suspend pin level
  input  wire logic [4:0]  autoLimit,       // automatic input limit
  output logic [2:0]       precharge_voltage_sel, // pre-charge voltage
  output logic [1:0]       precharge_current_sel, // pre-charge current
  output logic [1:0]       done_current_sel, // done current
  output logic [1:0]       fast_timer_sel,  // fast-charge timer code
  output logic [1:0]       pre_timer_sel,   // pre-charge timer code
  output logic             weak_cell_check_en, // weak-cell check enable
  output logic [4:0]       inputLimit,      // applied input limit code
  output logic             suspendActive,   // effective suspend request
  output logic             restartCharge,   // pulse: restart from done
  output logic [1:0]       chargeState      // maintain-phase state
);
  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  logic rstMeta_r, rstSync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_n <= rstMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // register storage and bus slave
  // ----------------------------------------------------------------
  logic [7:0]  prechgDone_r, prechgDone_nxt, chgTimer_r, chgTimer_nxt;
  logic [7:0]  weakCtl_r, weakCtl_nxt, inLimit_r, inLimit_nxt;
  logic        bValid_r, bValid_nxt, rValid_r, rValid_nxt;
  logic [1:0]  bResp_r, bResp_nxt, rResp_r, rResp_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic        wrFire, rdFire;
  logic [7:0]  wIdx, rIdx, wByte;
  ccr_chg_t    state_r, state_nxt;

  // merges one byte through a writable mask; the caller checks the lane-0 strobe
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] val,
                                       input logic [7:0] msk);
    merge = (old & ~msk) | (val & msk);
  endfunction

  // address and data are taken together; no buffering, one write at a time
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bValid_r;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = s_axi_arvalid && !rValid_r;
  assign wrFire = s_axi_awready;
  assign rdFire = s_axi_arready;
  assign wIdx   = s_axi_awaddr[9:2];
  assign rIdx   = s_axi_araddr[9:2];
  assign wByte  = s_axi_wdata[7:0];

  // write path: protected writes answer okay but store nothing
  always_comb begin
    prechgDone_nxt = prechgDone_r;
    chgTimer_nxt   = chgTimer_r;
    weakCtl_nxt    = weakCtl_r;
    inLimit_nxt    = inLimit_r;
    bValid_nxt     = bValid_r && !s_axi_bready;
    bResp_nxt      = bResp_r;
    if (wrFire) begin
      bValid_nxt = 1'b1;
      bResp_nxt  = RESP_OKAY;
      unique case (wIdx)
        IDX_PRECHG_DONE: if (!write_protect_flag && s_axi_wstrb[0]) begin // R1
          prechgDone_nxt = merge(prechgDone_r, wByte, MSK_PRECHG_DONE);
        end
        IDX_CHG_TIMER: if (!write_protect_flag && s_axi_wstrb[0]) begin // R1
          chgTimer_nxt = merge(chgTimer_r, wByte, MSK_CHG_TIMER);
        end
        IDX_WEAK_CELL: if (!write_protect_flag && s_axi_wstrb[0]) begin // R7
          weakCtl_nxt = merge(weakCtl_r, wByte, MSK_WEAK_CELL);
        end
        IDX_INPUT_LIMIT: if (!write_protect_flag && s_axi_wstrb[0]) begin // R1
          inLimit_nxt = merge(inLimit_r, wByte, MSK_INPUT_LIMIT);
        end
        IDX_PROTECT, IDX_CHG_STATUS: ;
        default: bResp_nxt = RESP_SLVERR;
      endcase
    end
  end

  // read path: weak-cell state is sampled live from the detector
  always_comb begin
    rValid_nxt = rValid_r && !s_axi_rready;
    rResp_nxt  = rResp_r;
    rData_nxt  = rData_r;
    if (rdFire) begin
      rValid_nxt = 1'b1;
      rResp_nxt  = RESP_OKAY;
      rData_nxt  = 32'h0;
      unique case (rIdx)
        IDX_PRECHG_DONE: rData_nxt[7:0] = prechgDone_r;
        IDX_CHG_TIMER:   rData_nxt[7:0] = chgTimer_r;
        IDX_WEAK_CELL:   rData_nxt[7:0] = {weak_cell_state, weakCtl_r[4:0]}; // R7
        IDX_INPUT_LIMIT: rData_nxt[7:0] = inLimit_r;
        IDX_PROTECT:     rData_nxt[0]   = write_protect_flag;
        IDX_CHG_STATUS:  rData_nxt[1:0] = state_r;
        default:         rResp_nxt      = RESP_SLVERR;
      endcase
    end
  end

  // register stage for the bank and bus answers
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      prechgDone_r <= RST_PRECHG_DONE;
      chgTimer_r   <= RST_CHG_TIMER;
      weakCtl_r    <= RST_WEAK_CELL;
      inLimit_r    <= RST_INPUT_LIMIT;
      bValid_r     <= 1'b0;
      bResp_r      <= RESP_OKAY;
      rValid_r     <= 1'b0;
      rResp_r      <= RESP_OKAY;
      rData_r      <= 32'h0;
    end else begin
      prechgDone_r <= prechgDone_nxt;
      chgTimer_r   <= chgTimer_nxt;
      weakCtl_r    <= weakCtl_nxt;
      inLimit_r    <= inLimit_nxt;
      bValid_r     <= bValid_nxt;
      bResp_r      <= bResp_nxt;
      rValid_r     <= rValid_nxt;
      rResp_r      <= rResp_nxt;
      rData_r      <= rData_nxt;
    end
  end

  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp  = bResp_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rresp  = rResp_r;
  assign s_axi_rdata  = rData_r;

  // ----------------------------------------------------------------
  // field outputs to the analogue charger
  // ----------------------------------------------------------------
  assign precharge_voltage_sel = prechgDone_r[6:4];
  assign precharge_current_sel = prechgDone_r[3:2];
  assign done_current_sel      = prechgDone_r[1:0];
  assign fast_timer_sel        = chgTimer_r[3:2];
  assign pre_timer_sel         = chgTimer_r[1:0];
  assign weak_cell_check_en    = weakCtl_r[BIT_WEAK_EN]; // R7
  // forced limit wins when override set; reserved codes are passed unchanged
  assign inputLimit    = inLimit_r[BIT_OVERRIDE] ? inLimit_r[4:0] : autoLimit; // R4
  assign suspendActive = suspend_pin && !inLimit_r[BIT_SUSP_MASK]; // R5

  // ----------------------------------------------------------------
  // maintain-charge sequencer
  // ----------------------------------------------------------------
  logic [7:0] maintMin;
  logic       timerStart, timerDone, restart_nxt, restart_r;

  always_comb begin
    unique case (chgTimer_r[LSB_MAINT_TMR +: 2]) // R3
      2'h0: maintMin = MT_MIN_00;
      2'h1: maintMin = MT_MIN_01;
      2'h2: maintMin = MT_MIN_10;
      2'h3: maintMin = MT_MIN_11;
    endcase
  end

  ccr_min_timer #(.MINUTE(MINUTE)) u_timer (
    .clk       (clk),
    .rstSync_n (rstSync_n),
    .start     (timerStart),
    .minutes   (maintMin),
    .expired   (timerDone)
  );

  // done is reached only with auto-stop; restart only when enabled
  always_comb begin
    state_nxt   = state_r;
    timerStart  = 1'b0;
    restart_nxt = 1'b0;
    unique case (state_r)
      CHG_IDLE: if (charge_enter) begin
        state_nxt  = CHG_MAINTAIN;
        timerStart = 1'b1;
      end
      CHG_MAINTAIN: if (timerDone && auto_stop_ctl) state_nxt = CHG_DONE; // R6
      CHG_DONE: if (belowRecharge && chgTimer_r[BIT_AUTO_RESTART]) begin // R2
        state_nxt   = CHG_IDLE;
        restart_nxt = 1'b1;
      end
      default: state_nxt = CHG_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_r   <= CHG_IDLE;
      restart_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      restart_r <= restart_nxt;
    end
  end

  assign restartCharge = restart_r;
  assign chargeState   = state_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence protWrite;
    wrFire && write_protect_flag && wIdx == IDX_CHG_TIMER;
  endsequence
  chk_protect_holds: assert property (@(posedge clk) disable iff (!rstSync_n) // R1
    protWrite |=> $stable(chgTimer_r)) else $error("protected write changed register");
  chk_stay_done: assert property (@(posedge clk) disable iff (!rstSync_n) // R2
    state_r == CHG_DONE && !chgTimer_r[BIT_AUTO_RESTART] |=> state_r == CHG_DONE)
    else $error("left done without auto-restart");
  chk_restart_go: assert property (@(posedge clk) disable iff (!rstSync_n) // R2
    state_r == CHG_DONE && belowRecharge && chgTimer_r[BIT_AUTO_RESTART]
    |=> restartCharge && state_r == CHG_IDLE) else $error("no restart");
  chk_zero_timer: assert property (@(posedge clk) disable iff (!rstSync_n) // R3
    timerStart && maintMin == MT_MIN_00 |=> timerDone) else $error("zero minutes not at once");
  chk_force_limit: assert property (@(posedge clk) disable iff (!rstSync_n) // R4
    inLimit_r[BIT_OVERRIDE] |-> inputLimit == inLimit_r[4:0]) else $error("limit not forced");
  chk_auto_limit: assert property (@(posedge clk) disable iff (!rstSync_n) // R4
    !inLimit_r[BIT_OVERRIDE] |-> inputLimit == autoLimit) else $error("limit not automatic");
  chk_suspend_mask: assert property (@(posedge clk) disable iff (!rstSync_n) // R5
    inLimit_r[BIT_SUSP_MASK] |-> !suspendActive) else $error("masked suspend seen");
  chk_auto_stop: assert property (@(posedge clk) disable iff (!rstSync_n) // R6
    state_r == CHG_MAINTAIN && !auto_stop_ctl |=> state_r != CHG_DONE)
    else $error("done without auto-stop");
  chk_weak_ro: assert property (@(posedge clk) disable iff (!rstSync_n) // R7
    rdFire && rIdx == IDX_WEAK_CELL |=> s_axi_rdata[7:5] == $past(weak_cell_state))
    else $error("weak state readback wrong");
endmodule // ccr_charger_regs

// File: test/ccr_charger_regs_bench.sv
// bench for the charger control register bank, driving every port by hand
// assumes the bank answers over axi4-lite and runs with a 4-cycle minute
module ccr_charger_regs_bench import ccr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int           MIN = 4;
  localparam logic [7:0]   IDX [4] = '{IDX_PRECHG_DONE, IDX_CHG_TIMER,
                                       IDX_WEAK_CELL, IDX_INPUT_LIMIT};
  localparam logic [7:0]   MSK [4] = '{MSK_PRECHG_DONE, MSK_CHG_TIMER,
                                       MSK_WEAK_CELL, MSK_INPUT_LIMIT};
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, chargeState, pcSel, dcSel, ftSel, ptSel;
  logic        wp, autoStop, chargeEnter, belowRecharge, suspendPin, weakEn;
  logic        suspendActive, restartCharge;
  logic [2:0]  weakState, pvSel;
  logic [4:0]  autoLimit, inputLimit;
  int          numErrors, checkCount, restarts;

  ccr_charger_regs #(.MINUTE(MIN)) dut (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .write_protect_flag(wp), .auto_stop_ctl(autoStop), .charge_enter(chargeEnter),
    .belowRecharge(belowRecharge), .weak_cell_state(weakState), .suspend_pin(suspendPin),
    .autoLimit(autoLimit), .precharge_voltage_sel(pvSel), .precharge_current_sel(pcSel),
    .done_current_sel(dcSel), .fast_timer_sel(ftSel), .pre_timer_sel(ptSel),
    .weak_cell_check_en(weakEn), .inputLimit(inputLimit), .suspendActive(suspendActive),
    .restartCharge(restartCharge), .chargeState(chargeState));

  // clock, and a restart-pulse counter sampled mid-cycle so it sees settled values
  always #25 clk = ~clk;
  always @(negedge clk) if (restartCharge === 1'b1) restarts++;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d of %0d checks", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ready is looked at 1 ns after an edge, i.e. the value the next edge samples;
  // no cycle count is assumed, only the watchdog ends a wait that never finishes
  task automatic axi_write(input logic [7:0] idx, input logic [7:0] d, input ccr_resp_t er);
    logic hs;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      #1 hs = (awready === 1'b1) && (wready === 1'b1);
      @(posedge clk);
    end while (!hs);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin
      #1 hs = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
    end while (!hs);
    bready <= 1'b0;
    check_val("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic axi_read(input logic [7:0] idx, input ccr_resp_t er);
    logic hs;
    logic [1:0] r;
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      #1 hs = (arready === 1'b1);
      @(posedge clk);
    end while (!hs);
    arvalid <= 1'b0;
    do begin
      #1 hs = (rvalid === 1'b1);
      r = rresp;
      rd = rdata;
      @(posedge clk);
    end while (!hs);
    rready <= 1'b0;
    check_val("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_write_masks();
    for (int i = 0; i < 4; i++) begin
      axi_read(IDX[i], RESP_OKAY);
      check_val("resetValue", 32'h0, rd);
      axi_write(IDX[i], 8'hff, RESP_OKAY);
      axi_read(IDX[i], RESP_OKAY);
      check_val("writtenBits", {24'h0, MSK[i]}, rd);
    end
    check_val("fieldOutputs", 32'h7ff, {pvSel, pcSel, dcSel, ftSel, ptSel});
    check_val("weakEnable", 32'h1, {31'h0, weakEn});
  endtask

  // protected writes are answered but store nothing; status stays live
  task automatic t_protect();
    wp <= 1'b1;
    weakState <= 3'h5;
    axi_read(IDX_PROTECT, RESP_OKAY);
    check_val("protectStatus", 32'h1, rd);
    for (int i = 0; i < 4; i++) begin
      axi_write(IDX[i], 8'h00, RESP_OKAY);
      axi_read(IDX[i], RESP_OKAY);
      check_val("protectedReg", {24'h0, MSK[i] | (i == 2 ? 8'ha0 : 8'h00)}, rd);
    end
    wp <= 1'b0;
    weakState <= 3'h0;
    // a write with lane 0 strobed off must leave the byte alone
    wstrb <= 4'h0;
    axi_write(IDX_PRECHG_DONE, 8'h00, RESP_OKAY);
    wstrb <= 4'hf;
    axi_read(IDX_PRECHG_DONE, RESP_OKAY);
    check_val("strobeOff", {24'h0, MSK_PRECHG_DONE}, rd);
    // a mixed pattern shows each field lands on its own output
    axi_write(IDX_PRECHG_DONE, 8'h5a, RESP_OKAY);
    check_val("fieldSplit", 32'h5a, {25'h0, pvSel, pcSel, dcSel});
    axi_write(8'h40, 8'h12, RESP_SLVERR);
    axi_read(8'h40, RESP_SLVERR);
  endtask

  task automatic t_limit();
    autoLimit <= 5'h13;
    suspendPin <= 1'b1;
    // forced code stays clear of the two reserved codes
    axi_write(IDX_INPUT_LIMIT, 8'h9d, RESP_OKAY);
    check_val("forcedLimit", 32'h1d, {27'h0, inputLimit});
    check_val("suspendLive", 32'h1, {31'h0, suspendActive});
    axi_write(IDX_INPUT_LIMIT, 8'h41, RESP_OKAY);
    check_val("autoLimit", 32'h13, {27'h0, inputLimit});
    check_val("suspendMasked", 32'h0, {31'h0, suspendActive});
  endtask

  // every maintain code; done then waits for the restart bit before going idle
  task automatic t_timer();
    int n;
    int r0;
    int mins [4] = '{0, 15, 30, 60};
    autoStop <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      axi_write(IDX_CHG_TIMER, 8'(c << 4), RESP_OKAY);
      chargeEnter <= 1'b1;
      @(posedge clk);
      chargeEnter <= 1'b0;
      n = 0;
      while (chargeState !== 2'(CHG_DONE) && n < 400) begin
        @(posedge clk);
        #1 n++;
      end
      check_val("maintainLong", 32'h1,
                {31'h0, n >= mins[c] * MIN && n <= mins[c] * MIN + 6});
      @(posedge clk);
      r0 = restarts;
      belowRecharge <= 1'b1;
      repeat (10) @(posedge clk);
      check_val("holdDone", {30'h0, 2'(CHG_DONE)}, {30'h0, chargeState});
      axi_write(IDX_CHG_TIMER, 8'h40 | 8'(c << 4), RESP_OKAY);
      repeat (3) @(posedge clk);
      check_val("restarts", r0 + 1, restarts);
      check_val("backToIdle", {30'h0, 2'(CHG_IDLE)}, {30'h0, chargeState});
      belowRecharge <= 1'b0;
    end
  endtask

  task automatic t_autostop();
    autoStop <= 1'b0;
    axi_write(IDX_CHG_TIMER, 8'h00, RESP_OKAY);
    chargeEnter <= 1'b1;
    @(posedge clk);
    chargeEnter <= 1'b0;
    repeat (20) @(posedge clk);
    check_val("noAutoStop", {30'h0, 2'(CHG_MAINTAIN)}, {30'h0, chargeState});
    axi_read(IDX_CHG_STATUS, RESP_OKAY);
    check_val("statusMaintain", {30'h0, 2'(CHG_MAINTAIN)}, rd);
  endtask

  // ------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    {clk, rst_n, awvalid, wvalid, bready, arvalid, rready, wp, autoStop} = '0;
    {chargeEnter, belowRecharge, suspendPin, weakState, autoLimit} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_write_masks();
    t_protect();
    t_limit();
    t_timer();
    t_autostop();
    stop_test();
  end

  initial begin
    #(50 * 20000);
    numErrors++;
    stop_test();
  end
endmodule // ccr_charger_regs_bench
